// >>> tag_cfg_pkg.sv
// shared constants and carrier types for the tag configuration bank
package tag_cfg_pkg;
    localparam logic [11:0] protect_map_addr = 12'h800;
    localparam logic [11:0] config_byte_addr = 12'h910;
    localparam logic [11:0] control_reg_addr = 12'h920;
    localparam int sector_count = 16;
    localparam int sector_addr_lsb = 7;
    localparam logic [15:0] protect_map_reset = 16'h0000;
    localparam logic [7:0] config_byte_delivery = 8'hf4;
    localparam int cfg_pin_mode_bit = 3;
    localparam int cfg_harvest_default_off_bit = 2;
    localparam int cfg_sink_level_hi_bit = 1;
    localparam int cfg_sink_level_lo_bit = 0;
    localparam int ctl_write_done_bit = 7;
    localparam int ctl_field_present_bit = 1;
    localparam int ctl_harvest_enable_bit = 0;
    localparam logic [7:0] ctl_writable_mask = 8'h01;

    typedef enum logic [2:0] {
        rf_cmd_none,
        rf_read_config_cmd,
        rf_write_harvest_cfg_cmd,
        rf_write_pin_cfg_cmd,
        rf_read_control_cmd,
        rf_set_harvest_enable_cmd
    } rf_cmd_t;

    typedef enum logic [1:0] {
        act_idle,
        act_frame,
        act_exec,
        act_write
    } act_state_t;

    // serial-bus byte access from the protocol engine
    typedef struct packed {
        logic rd;
        logic wr;
        logic chip_enable_select_bit;
        logic [11:0] addr;
        logic [7:0] wdata;
    } ser_req_t;

    // rf command event from the rf front end
    typedef struct packed {
        logic valid;
        rf_cmd_t cmd;
        logic [7:0] wdata;
    } rf_req_t;
endpackage

// >>> nv_byte_store.sv
// small non-volatile byte store holding protect map and configuration byte
`timescale 1ns/1ps
module nv_byte_store #(
    parameter int depth = 3,
    parameter logic [7:0] init_val [3] = '{8'h00, 8'h00, 8'hf4}
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    // write port
    input wire logic wr_en,
    input wire logic [1:0] wr_idx,
    input wire logic [7:0] wr_data,
    // registered contents
    output logic [7:0] mem_q [depth]
);
    // reset value stands for the contents kept across power cycles
    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            for (int i = 0; i < depth; i++) begin
                mem_q[i] <= init_val[i];
            end
        end else if (wr_en && int'(wr_idx) < depth) begin
            mem_q[wr_idx] <= wr_data;
        end
    end
endmodule // nv_byte_store

// >>> write_cycle_timer.sv
// counts the internal write time and reports completion
`timescale 1ns/1ps
module write_cycle_timer #(
    parameter int write_cycles = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_b,
    // control
    input wire logic start,
    input wire logic abort,
    // status
    output logic busy,
    output logic done
);
    typedef struct packed {
        logic [15:0] cnt;
        logic busy;
        logic done;
    } tmr_state_t;

    tmr_state_t st_reg;
    tmr_state_t st_next;

    always_comb begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (start) begin
            st_next.busy = 1'b1;
            st_next.cnt = 16'(write_cycles);
        end else if (st_reg.busy && abort) begin
            st_next.busy = 1'b0;
        end else if (st_reg.busy) begin
            if (st_reg.cnt <= 16'h0001) begin
                st_next.busy = 1'b0;
                st_next.done = 1'b1;
            end else begin
                st_next.cnt = st_reg.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.busy;
    assign done = st_reg.done;
endmodule // write_cycle_timer

// >>> tag_sector_lock_and_config_regs.sv
// sector write-protect map, configuration byte and control register of the tag
`timescale 1ns/1ps
//
// Behaviour
// - sixteen protect bits, one per sector
// - protect map at 2048, chip enable select
// - map bit n governs sector n
// - map reads always; writes need password
// - protect map delivered as all zero
// - config byte at 2320, field layout
// - busy mode: low from sof to end
// - bad command: low only until crc
// - field loss releases activity output
// - busy mode: released during serial commands
// - write mode: low during rf write only
// - two bits select sink level
// - control reg at 2336, bits 7:1 read-only
// - harvest enable gates harvest output
// - write flag cleared at start, set done
// - power-up enable is inverse of default
// - field-present shows rf power sufficient
// - rf control read returns field as one
// - config byte serial access always allowed
// - control reg serial access always allowed
// - rf config read and partial writes
// - rf control read and enable write
// - protected sectors locked until password
module tag_sector_lock_and_config_regs #(
    parameter int sectors = tag_cfg_pkg::sector_count,
    parameter int write_cycles = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // serial-bus byte access
    input wire tag_cfg_pkg::ser_req_t ser_req,
    input wire logic ser_busy,
    input wire logic password_ok,
    output logic [7:0] ser_rdata,
    output logic ser_write_refused,
    output logic user_write_en,
    // rf command side
    input wire tag_cfg_pkg::rf_req_t rf_req,
    input wire logic rf_sof,
    input wire logic rf_crc_rx,
    input wire logic rf_cmd_bad,
    input wire logic rf_exec_done,
    input wire logic rf_write_valid,
    input wire logic rf_reply_start,
    input wire logic field_present,
    output logic [7:0] rf_rdata,
    output logic rf_rdata_valid,
    // pins
    output logic rf_activity_output_o,
    output logic rf_activity_output_oe,
    output logic harvest_out_en,
    output logic [1:0] harvest_sink_level,
    output logic write_busy
);
    typedef struct packed {
        logic [1:0] rst_pipe;
    } sync_state_t;

    typedef struct packed {
        tag_cfg_pkg::act_state_t act;
        logic harvest_enable;
        logic write_done;
        logic boot_load;
        logic [7:0] rf_rdata;
        logic rf_rdata_valid;
        logic [7:0] ser_rdata;
        logic ser_write_refused;
        logic user_write_en;
    } core_state_t;

    sync_state_t sy_reg;
    logic rst_sync_b;
    core_state_t st_reg;
    core_state_t st_next;
    logic [7:0] nv_q [3];
    logic nv_wr;
    logic [1:0] nv_idx;
    logic [7:0] nv_data;
    logic [15:0] protect_map;
    logic [7:0] config_byte;
    logic [7:0] control_view;
    logic tmr_start;
    logic tmr_busy;
    logic tmr_done;
    logic sector_locked;
    logic ser_sys;

    // reset released through two flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sy_reg <= '0;
        end else begin
            sy_reg.rst_pipe <= {sy_reg.rst_pipe[0], 1'b1};
        end
    end
    assign rst_sync_b = sy_reg.rst_pipe[1];

    // index 0/1: protect map low/high, index 2: configuration byte
    nv_byte_store #(
        .depth(3),
        .init_val('{tag_cfg_pkg::protect_map_reset[7:0], tag_cfg_pkg::protect_map_reset[15:8],
            tag_cfg_pkg::config_byte_delivery})
    ) u_store (
        .clk_sys(clk_sys),
        .rst_sync_b(rst_sync_b),
        .wr_en(nv_wr),
        .wr_idx(nv_idx),
        .wr_data(nv_data),
        .mem_q(nv_q)
    );

    write_cycle_timer #(
        .write_cycles(write_cycles)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_sync_b(rst_sync_b),
        .start(tmr_start),
        .abort(1'b0),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    assign protect_map = {nv_q[1], nv_q[0]};
    assign config_byte = nv_q[2];

    // system area only answers with chip enable select at one
    assign ser_sys = ser_req.chip_enable_select_bit;

    // sector n sits in the n-th 128-byte slice of user memory
    assign sector_locked = protect_map[ser_req.addr[10:tag_cfg_pkg::sector_addr_lsb]] &&
        !password_ok;

    always_comb begin
        control_view = 8'h00;
        control_view[tag_cfg_pkg::ctl_write_done_bit] = st_reg.write_done;
        control_view[tag_cfg_pkg::ctl_field_present_bit] = field_present;
        control_view[tag_cfg_pkg::ctl_harvest_enable_bit] = st_reg.harvest_enable;
    end

    always_comb begin
        st_next = st_reg;
        nv_wr = 1'b0;
        nv_idx = 2'd0;
        nv_data = 8'h00;
        tmr_start = 1'b0;
        st_next.rf_rdata_valid = 1'b0;
        st_next.ser_write_refused = 1'b0;
        st_next.user_write_en = 1'b0;
        st_next.boot_load = 1'b0;
        if (st_reg.boot_load) begin
            st_next.harvest_enable =
                !config_byte[tag_cfg_pkg::cfg_harvest_default_off_bit];
        end
        if (ser_req.wr) begin
            st_next.write_done = 1'b0;
        end
        // completion in the same cycle as a new write start still reports done
        if (tmr_done) begin
            st_next.write_done = 1'b1;
        end
        // serial reads always permitted
        if (ser_req.rd) begin
            st_next.ser_rdata = 8'h00;
            if (ser_sys) begin
                case (ser_req.addr)
                    tag_cfg_pkg::protect_map_addr: st_next.ser_rdata = nv_q[0];
                    tag_cfg_pkg::protect_map_addr + 12'h001: st_next.ser_rdata = nv_q[1];
                    tag_cfg_pkg::config_byte_addr: st_next.ser_rdata = config_byte;
                    tag_cfg_pkg::control_reg_addr: st_next.ser_rdata = control_view;
                    default: st_next.ser_rdata = 8'h00;
                endcase
            end
        end
        if (ser_req.wr) begin
            tmr_start = 1'b1;
            if (ser_sys) begin
                case (ser_req.addr)
                    tag_cfg_pkg::protect_map_addr,
                    tag_cfg_pkg::protect_map_addr + 12'h001: begin
                        if (password_ok) begin
                            nv_wr = 1'b1;
                            nv_idx = {1'b0, ser_req.addr[0]};
                            nv_data = ser_req.wdata;
                        end else begin
                            st_next.ser_write_refused = 1'b1;
                        end
                    end
                    tag_cfg_pkg::config_byte_addr: begin
                        nv_wr = 1'b1;
                        nv_idx = 2'd2;
                        nv_data = ser_req.wdata;
                    end
                    tag_cfg_pkg::control_reg_addr: begin
                        st_next.harvest_enable =
                            ser_req.wdata[tag_cfg_pkg::ctl_harvest_enable_bit];
                    end
                    default: st_next.ser_write_refused = 1'b1;
                endcase
            end else if (sector_locked) begin
                st_next.ser_write_refused = 1'b1;
            end else begin
                st_next.user_write_en = 1'b1;
            end
        end else if (rf_req.valid) begin
            // rf commands only land when no serial write is presented in the same cycle
            case (rf_req.cmd)
                tag_cfg_pkg::rf_read_config_cmd: begin
                    st_next.rf_rdata = config_byte;
                    st_next.rf_rdata_valid = 1'b1;
                end
                tag_cfg_pkg::rf_write_harvest_cfg_cmd: begin
                    nv_wr = 1'b1;
                    nv_idx = 2'd2;
                    nv_data = config_byte;
                    nv_data[2:0] = rf_req.wdata[2:0];
                end
                tag_cfg_pkg::rf_write_pin_cfg_cmd: begin
                    nv_wr = 1'b1;
                    nv_idx = 2'd2;
                    nv_data = config_byte;
                    nv_data[tag_cfg_pkg::cfg_pin_mode_bit] =
                        rf_req.wdata[tag_cfg_pkg::cfg_pin_mode_bit];
                end
                tag_cfg_pkg::rf_read_control_cmd: begin
                    st_next.rf_rdata = control_view;
                    st_next.rf_rdata[tag_cfg_pkg::ctl_write_done_bit] = 1'b0;
                    st_next.rf_rdata[tag_cfg_pkg::ctl_field_present_bit] = 1'b1;
                    st_next.rf_rdata_valid = 1'b1;
                end
                tag_cfg_pkg::rf_set_harvest_enable_cmd: begin
                    st_next.harvest_enable =
                        rf_req.wdata[tag_cfg_pkg::ctl_harvest_enable_bit];
                end
                default: ;
            endcase
        end
        // activity output sequencing
        case (st_reg.act)
            tag_cfg_pkg::act_idle: begin
                if (!config_byte[tag_cfg_pkg::cfg_pin_mode_bit]) begin
                    if (rf_sof && field_present) begin
                        st_next.act = tag_cfg_pkg::act_frame;
                    end
                end else if (rf_write_valid && field_present) begin
                    st_next.act = tag_cfg_pkg::act_write;
                end
            end
            tag_cfg_pkg::act_frame: begin
                if (rf_crc_rx) begin
                    st_next.act = rf_cmd_bad ? tag_cfg_pkg::act_idle :
                        tag_cfg_pkg::act_exec;
                end
            end
            tag_cfg_pkg::act_exec: begin
                if (rf_exec_done) begin
                    st_next.act = tag_cfg_pkg::act_idle;
                end
            end
            tag_cfg_pkg::act_write: begin
                if (rf_reply_start) begin
                    st_next.act = tag_cfg_pkg::act_idle;
                end
            end
            default: st_next.act = tag_cfg_pkg::act_idle;
        endcase
        if (!field_present) begin
            st_next.act = tag_cfg_pkg::act_idle;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_reg <= '0;
            st_reg.boot_load <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // field loss also releases the pin combinationally, without waiting a clock
    always_comb begin
        rf_activity_output_o = 1'b0;
        rf_activity_output_oe = 1'b0;
        if (field_present && st_reg.act != tag_cfg_pkg::act_idle) begin
            // serial activity keeps the pin released in both modes
            rf_activity_output_oe = !ser_busy;
        end
    end

    assign harvest_out_en = st_reg.harvest_enable;
    assign harvest_sink_level = {config_byte[tag_cfg_pkg::cfg_sink_level_hi_bit],
        config_byte[tag_cfg_pkg::cfg_sink_level_lo_bit]};
    assign write_busy = tmr_busy;
    assign ser_rdata = st_reg.ser_rdata;
    assign ser_write_refused = st_reg.ser_write_refused;
    assign user_write_en = st_reg.user_write_en;
    assign rf_rdata = st_reg.rf_rdata;
    assign rf_rdata_valid = st_reg.rf_rdata_valid;
endmodule // tag_sector_lock_and_config_regs

// >>> tag_cfg_chk.sv
// port-level assertion checker for the tag configuration bank
`timescale 1ns/1ps
module tag_cfg_chk (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // serial side
    input wire tag_cfg_pkg::ser_req_t ser_req,
    input wire logic ser_busy,
    input wire logic password_ok,
    input wire logic ser_write_refused,
    input wire logic user_write_en,
    // rf side
    input wire tag_cfg_pkg::rf_req_t rf_req,
    input wire logic rf_sof,
    input wire logic rf_crc_rx,
    input wire logic rf_cmd_bad,
    input wire logic rf_write_valid,
    input wire logic field_present,
    input wire logic [7:0] rf_rdata,
    input wire logic rf_rdata_valid,
    // pins
    input wire logic rf_activity_output_o,
    input wire logic rf_activity_output_oe,
    input wire logic harvest_out_en,
    input wire logic [1:0] harvest_sink_level,
    input wire logic write_busy
);
    logic wip_reg;
    logic sys_wr;
    assign sys_wr = ser_req.wr && ser_req.chip_enable_select_bit;
    // mirror of pin mode bit, delivery value has it clear
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wip_reg <= 1'b0;
        end else if (sys_wr && ser_req.addr == tag_cfg_pkg::config_byte_addr) begin
            wip_reg <= ser_req.wdata[3];
        end else if (rf_req.valid && !ser_req.wr
            && rf_req.cmd == tag_cfg_pkg::rf_write_pin_cfg_cmd) begin
            wip_reg <= rf_req.wdata[3];
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    sequence s_hold;
        field_present && !ser_busy;
    endsequence
    sequence s_busy_sof;
        rf_sof && field_present && !ser_busy && !wip_reg;
    endsequence
    sequence s_wip_write;
        rf_write_valid && field_present && !ser_busy && wip_reg;
    endsequence
    a_pin_open_drain: assert property (rf_activity_output_o == 1'b0)
        else $error("activity pin driven high");
    a_sof_pulls_low: assert property (s_busy_sof ##1 s_hold |-> rf_activity_output_oe)
        else $error("activity pin not low after frame start");
    a_bad_crc_release: assert property (rf_crc_rx && rf_cmd_bad && !wip_reg |=>
        !rf_activity_output_oe)
        else $error("activity pin held after bad command");
    a_field_loss_release: assert property (!field_present |-> !rf_activity_output_oe)
        else $error("activity pin held without field");
    a_serial_busy_release: assert property (ser_busy |-> !rf_activity_output_oe)
        else $error("activity pin low during serial command");
    a_wip_pulls_low: assert property (s_wip_write ##1 s_hold |-> rf_activity_output_oe)
        else $error("activity pin not low during rf write");
    a_map_wr_refused: assert property (sys_wr && ser_req.addr[11:1] == 11'h400 && !password_ok
        |=> ser_write_refused && !user_write_en)
        else $error("protect map write accepted without password");
    a_cfg_wr_applied: assert property (sys_wr && ser_req.addr == tag_cfg_pkg::config_byte_addr
        |=> !ser_write_refused && write_busy
        && harvest_sink_level == $past(ser_req.wdata[1:0]))
        else $error("config write not applied");
    a_ctl_wr_enable: assert property (sys_wr && ser_req.addr == tag_cfg_pkg::control_reg_addr
        |=> !ser_write_refused && harvest_out_en == $past(ser_req.wdata[0]))
        else $error("control write not applied");
    a_rf_ctl_field: assert property (rf_req.valid && !ser_req.wr
        && rf_req.cmd == tag_cfg_pkg::rf_read_control_cmd
        |=> rf_rdata_valid && rf_rdata[7:1] == 7'h01)
        else $error("rf control read field bit wrong");
endmodule // tag_cfg_chk

bind tag_sector_lock_and_config_regs tag_cfg_chk chk_u (.*);

// >>> rf_reader_model.sv
// rf front end model issuing frame event pulses
`timescale 1ns/1ps
module rf_reader_model (
    // clock
    input wire logic clk_sys,
    // frame events
    output logic rf_sof,
    output logic rf_crc_rx,
    output logic rf_cmd_bad,
    output logic rf_exec_done,
    output logic rf_write_valid,
    output logic rf_reply_start
);
    logic [4:0] ev = 5'h00;
    assign {rf_reply_start, rf_write_valid, rf_exec_done, rf_crc_rx, rf_sof} = ev;
    initial rf_cmd_bad = 1'b0;
    task automatic step(input int i, input int gap);
        @(negedge clk_sys);
        ev[i] = 1'b1;
        @(negedge clk_sys);
        ev[i] = 1'b0;
        repeat (gap) @(negedge clk_sys);
    endtask
    // sof, crc, then for a good command end of execution or write and reply
    task automatic frame(input logic bad, input logic wr, input int gap);
        step(0, gap);
        rf_cmd_bad = bad;
        step(1, gap);
        // verdict only means something beside the crc pulse
        rf_cmd_bad = ~bad;
        if (!bad) step(wr ? 3 : 2, gap);
        if (!bad && wr) step(4, gap);
    endtask
endmodule // rf_reader_model

// >>> tb.sv
// self-checking bench for the tag configuration bank
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH %0t %h %h", $time, a, b); end end
module tb;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    tag_cfg_pkg::ser_req_t ser_req = '0;
    tag_cfg_pkg::rf_req_t rf_req = '0;
    logic ser_busy = 1'b0;
    logic password_ok = 1'b0;
    logic field_present = 1'b0;
    logic rf_sof, rf_crc_rx, rf_cmd_bad, rf_exec_done, rf_write_valid, rf_reply_start;
    logic [7:0] ser_rdata, rf_rdata;
    logic ser_write_refused, user_write_en, rf_rdata_valid, harvest_out_en, write_busy;
    logic rf_activity_output_o, rf_activity_output_oe;
    logic [1:0] harvest_sink_level;
    int bad_count = 0;
    int checked = 0;
    int oe_cnt = 0;
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (rf_activity_output_oe === 1'b1) oe_cnt++;
    // short write timer keeps the completion wait brief
    tag_sector_lock_and_config_regs #(.write_cycles(4)) dut_u (.*);
    rf_reader_model reader_u (.*);
    task automatic ser(input logic wr, input logic sel, input logic [11:0] a,
                       input logic [7:0] d);
        @(negedge clk_sys);
        ser_req = '{rd: !wr, wr: wr, chip_enable_select_bit: sel, addr: a, wdata: d};
        @(negedge clk_sys);
        ser_req = '0;
    endtask
    task automatic rf(input tag_cfg_pkg::rf_cmd_t c, input logic [7:0] d);
        @(negedge clk_sys);
        rf_req = '{valid: 1'b1, cmd: c, wdata: d};
        @(negedge clk_sys);
        rf_req = '0;
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < 50) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= 50) begin
            bad_count++;
            end_of_test();
        end
    endtask
    task automatic t_reset();
        `CHK(harvest_out_en, 1'b0)
        ser(0, 1, 12'h800, 8'h00);
        `CHK(ser_rdata, 8'h00)
        ser(0, 1, 12'h801, 8'h00);
        `CHK(ser_rdata, 8'h00)
        ser(0, 1, 12'h910, 8'h00);
        `CHK(ser_rdata[3:0], 4'h4)
        ser(0, 1, 12'h920, 8'h00);
        `CHK(ser_rdata, 8'h00)
    endtask
    task automatic t_map();
        logic [15:0] map;
        map = 16'h8005;
        ser(1, 1, 12'h800, 8'h05);
        `CHK(ser_write_refused, 1'b1)
        ser(0, 1, 12'h800, 8'h00);
        `CHK(ser_rdata, 8'h00)
        password_ok = 1'b1;
        ser(1, 1, 12'h800, map[7:0]);
        `CHK(ser_write_refused, 1'b0)
        ser(1, 1, 12'h801, map[15:8]);
        ser(0, 1, 12'h801, 8'h00);
        `CHK(ser_rdata, map[15:8])
        password_ok = 1'b0;
        for (int i = 0; i < 16; i++) begin
            ser(1, 0, 12'(i << 7), 8'ha5);
            `CHK(ser_write_refused, map[i])
            `CHK(user_write_en, !map[i])
        end
        password_ok = 1'b1;
        ser(1, 0, 12'h000, 8'ha5);
        `CHK(user_write_en, 1'b1)
        password_ok = 1'b0;
    endtask
    task automatic t_cfg();
        ser(1, 1, 12'h910, 8'h0b);
        `CHK(harvest_sink_level, 2'b11)
        ser(0, 1, 12'h920, 8'h00);
        `CHK(ser_rdata[7], 1'b0)
        wait_idle();
        ser(0, 1, 12'h920, 8'h00);
        `CHK(ser_rdata[7], 1'b1)
        ser(0, 1, 12'h910, 8'h00);
        `CHK(ser_rdata[3:0], 4'hb)
        ser(1, 1, 12'h920, 8'hff);
        `CHK(harvest_out_en, 1'b1)
        ser(0, 1, 12'h920, 8'h00);
        `CHK(ser_rdata[6:0], 7'h01)
        ser(1, 1, 12'h930, 8'h00);
        `CHK(ser_write_refused, 1'b1)
    endtask
    task automatic t_rf();
        field_present = 1'b1;
        rf(tag_cfg_pkg::rf_read_config_cmd, 8'h00);
        `CHK(rf_rdata[3:0], 4'hb)
        rf(tag_cfg_pkg::rf_write_harvest_cfg_cmd, 8'h06);
        `CHK(harvest_sink_level, 2'b10)
        rf(tag_cfg_pkg::rf_write_pin_cfg_cmd, 8'h00);
        ser(0, 1, 12'h910, 8'h00);
        `CHK(ser_rdata[3:0], 4'h6)
        rf(tag_cfg_pkg::rf_set_harvest_enable_cmd, 8'h00);
        `CHK(harvest_out_en, 1'b0)
        rf(tag_cfg_pkg::rf_read_control_cmd, 8'h00);
        `CHK(rf_rdata[1:0], 2'b10)
        ser(0, 1, 12'h920, 8'h00);
        `CHK(ser_rdata[1], 1'b1)
    endtask
    task automatic frame_cnt(input logic bad, input logic wr, output int c);
        oe_cnt = 0;
        reader_u.frame(bad, wr, 3);
        repeat (2) @(negedge clk_sys);
        c = oe_cnt;
    endtask
    task automatic t_pin();
        int good, badc, n;
        frame_cnt(0, 0, good);
        `CHK(good > 0, 1'b1)
        frame_cnt(1, 0, badc);
        `CHK(badc < good && badc > 0, 1'b1)
        ser_busy = 1'b1;
        frame_cnt(0, 0, n);
        `CHK(n, 0)
        ser_busy = 1'b0;
        field_present = 1'b0;
        frame_cnt(0, 0, n);
        `CHK(n, 0)
        field_present = 1'b1;
        rf(tag_cfg_pkg::rf_write_pin_cfg_cmd, 8'h08);
        frame_cnt(0, 0, n);
        `CHK(n, 0)
        frame_cnt(0, 1, n);
        `CHK(n > 0, 1'b1)
    endtask
    task automatic end_of_test();
        if (bad_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst_b = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_reset();
        t_map();
        t_cfg();
        t_rf();
        t_pin();
        end_of_test();
    end
endmodule // tb
